// ==== iss_ctrl_model.sv ====
// Remote controller model that issues commands and polls to the status core
`timescale 1ns/1ns
module iss_ctrl_model import iss_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rsp_valid,
    input wire logic [15:0] i_rsp_data,
    output iss_cmd_t o_cmd,
    output logic o_cmd_valid,
    output logic [2:0] o_cmd_grp,
    output logic [15:0] o_cmd_wdata
);
    // Idle lines carry a scrambled word so a stale value never passes for data
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = ISS_CMD_NONE;
        o_cmd_grp = 3'h7;
        o_cmd_wdata = 16'h5A5A;
    end

    // One command: launched after an edge, held through the taking edge, answer next cycle
    task automatic xfer(input iss_cmd_t cmd, input logic [2:0] grp, input logic [15:0] wd,
                        output logic got, output logic [15:0] rd);
        @(posedge i_ref_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd = cmd;
        o_cmd_grp = grp;
        o_cmd_wdata = wd;
        @(posedge i_ref_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd = ISS_CMD_NONE;
        o_cmd_grp = ~grp;
        o_cmd_wdata = ~wd;
        got = i_rsp_valid;
        rd = i_rsp_data;
    endtask : xfer
endmodule : iss_ctrl_model

// ==== iss_grp_if.sv ====
// Carrier between the core and one lower status register group
`timescale 1ns/1ns
interface iss_grp_if;
    logic [15:0] cond;
    logic [15:0] wdata;
    logic wr_ptr;
    logic wr_ntr;
    logic wr_en;
    logic rd_evt;
    logic clr;
    logic [15:0] cond_q;
    logic [15:0] event_q;
    logic [15:0] enable_q;
    logic [15:0] ptr_q;
    logic [15:0] ntr_q;
    logic summary;
    modport grp (input cond, wdata, wr_ptr, wr_ntr, wr_en, rd_evt, clr,
        output cond_q, event_q, enable_q, ptr_q, ntr_q, summary);
    modport ctl (output cond, wdata, wr_ptr, wr_ntr, wr_en, rd_evt, clr,
        input cond_q, event_q, enable_q, ptr_q, ntr_q, summary);
endinterface : iss_grp_if

// ==== iss_pkg.sv ====
// Types shared by the status reporting block
package iss_pkg;
    typedef enum logic [3:0] {
        ISS_CMD_NONE, ISS_CMD_READ_COND, ISS_CMD_READ_EVT, ISS_CMD_READ_PTR,
        ISS_CMD_READ_NTR, ISS_CMD_READ_EN, ISS_CMD_WRITE_PTR, ISS_CMD_WRITE_NTR,
        ISS_CMD_WRITE_EN, ISS_CMD_CLEAR_STATUS, ISS_CMD_OPC_ARM, ISS_CMD_STB_QUERY,
        ISS_CMD_SERIAL_POLL, ISS_CMD_WRITE_SRE, ISS_CMD_READ_SRE
    } iss_cmd_t;
    typedef struct packed {
        logic [15:0] cond_prev;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] en;
        logic [15:0] evt;
    } iss_grp_state_t;
    typedef struct packed {
        logic [15:0] gen_evt;
        logic [15:0] gen_en;
        logic [7:0] sre;
        logic [7:0] stb;
        logic srq;
        logic opc_armed;
        logic rsp_valid;
        logic [15:0] rsp_data;
    } iss_top_state_t;
endpackage : iss_pkg

// ==== iss_regs.svh ====
// Widths, field positions, masks, select codes and reset values of the status reporting block
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH
`define ISS_GRP_W 16
`define ISS_STB_W 8
`define ISS_NGRP 4
// Summary byte bit positions
`define ISS_STB_ERRQ 2
`define ISS_STB_QSUM 3
`define ISS_STB_MSGP 4
`define ISS_STB_GSUM 5
`define ISS_STB_RQS 6
`define ISS_STB_OPSUM 7
// General event bit positions and writable mask
`define ISS_EV_OPC 0
`define ISS_EV_OQF 2
`define ISS_EV_ISF 3
`define ISS_EV_CNE 4
`define ISS_EV_MFC 5
`define ISS_EV_PWR 7
`define ISS_EV_MASK 16'h00BD
// Lower group bit positions
`define ISS_CLK_DET 0
`define ISS_CLK_GEN 1
`define ISS_SYM_LOSS 0
`define ISS_SYM_DONE 1
`define ISS_QS_CLK_A 5
`define ISS_QS_CLK_B 9
`define ISS_QS_SYM 12
// Implemented bits of each lower group and of the summary byte
`define ISS_CLK_MASK 16'h0003
`define ISS_SYM_MASK 16'h0003
`define ISS_QS_MASK 16'h1FE1
`define ISS_OP_MASK 16'hF998
`define ISS_STB_USED 8'hFC
// Group select codes
`define ISS_SEL_CLK 3'h0
`define ISS_SEL_SYM 3'h1
`define ISS_SEL_QS 3'h2
`define ISS_SEL_OP 3'h3
`define ISS_SEL_GEN 3'h4
// Reset values
`define ISS_PTR_RST 16'hFFFF
`define ISS_NTR_RST 16'h0000
`define ISS_EN_RST 16'h0000
`define ISS_SRE_RST 8'h00
`endif

// ==== iss_status_core.sv ====
// Status reporting core: summary byte, general event group and lower groups
`timescale 1ns/1ns
`include "iss_regs.svh"
module iss_status_core import iss_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_cmd_valid,
    input wire iss_cmd_t i_cmd,
    input wire logic [2:0] i_cmd_grp,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic i_ops_idle,
    input wire logic i_output_queue_fault,
    input wire logic i_instrument_specific_fault,
    input wire logic i_command_not_executable,
    input wire logic i_malformed_command,
    input wire logic i_error_queue_nonempty,
    input wire logic i_output_message_pending,
    input wire logic i_detector_clock_missing,
    input wire logic i_generator_clock_missing,
    input wire logic i_symbol_align_lost,
    input wire logic i_symbol_align_done,
    input wire logic [15:0] i_questionable_cond,
    input wire logic [15:0] i_operation_cond,
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    output logic o_srq,
    output logic [7:0] o_summary_byte
);
    localparam logic [15:0] GRP_MASK [`ISS_NGRP] = '{`ISS_CLK_MASK, `ISS_SYM_MASK,
        `ISS_QS_MASK, `ISS_OP_MASK};

    iss_top_state_t s;
    iss_top_state_t next_s;
    iss_grp_if grp_if [`ISS_NGRP] ();
    logic [`ISS_NGRP-1:0] sums;
    logic [15:0] g_cond [`ISS_NGRP];
    logic [15:0] g_evt [`ISS_NGRP];
    logic [15:0] g_en [`ISS_NGRP];
    logic [15:0] g_ptr [`ISS_NGRP];
    logic [15:0] g_ntr [`ISS_NGRP];
    logic clr_all;
    logic sel_gen;
    logic [15:0] gen_set;
    logic gen_summary;
    logic master_summary;
    logic [7:0] sum_bits;
    logic [7:0] stb_now;
    logic [15:0] qs_cond;

    // Command decode shared by all groups
    assign clr_all = i_cmd_valid && (i_cmd == ISS_CMD_CLEAR_STATUS);
    assign sel_gen = (i_cmd_grp == `ISS_SEL_GEN);

    // Lower groups; the questionable group is fed by the clock and symbol summaries
    assign grp_if[0].cond = {14'h0000, i_generator_clock_missing,
        i_detector_clock_missing};
    assign grp_if[1].cond = {14'h0000, i_symbol_align_done, i_symbol_align_lost};
    assign qs_cond = (i_questionable_cond & ~((16'h0001 << `ISS_QS_CLK_A)
        | (16'h0001 << `ISS_QS_CLK_B) | (16'h0001 << `ISS_QS_SYM)))
        | ({15'h0000, sums[0]} << `ISS_QS_CLK_A)
        | ({15'h0000, sums[0]} << `ISS_QS_CLK_B)
        | ({15'h0000, sums[1]} << `ISS_QS_SYM);
    assign grp_if[2].cond = qs_cond;
    assign grp_if[3].cond = i_operation_cond;

    // Per group strobes and collected read values
    for (genvar gi = 0; gi < `ISS_NGRP; gi++) begin : g_grp
        localparam logic [2:0] SEL = 3'(gi);
        logic hit;
        assign hit = i_cmd_valid && (i_cmd_grp == SEL);
        assign grp_if[gi].wdata = i_cmd_wdata;
        assign grp_if[gi].wr_ptr = hit && (i_cmd == ISS_CMD_WRITE_PTR);
        assign grp_if[gi].wr_ntr = hit && (i_cmd == ISS_CMD_WRITE_NTR);
        assign grp_if[gi].wr_en = hit && (i_cmd == ISS_CMD_WRITE_EN);
        assign grp_if[gi].rd_evt = hit && (i_cmd == ISS_CMD_READ_EVT);
        assign grp_if[gi].clr = clr_all;
        assign sums[gi] = grp_if[gi].summary;
        assign g_cond[gi] = grp_if[gi].cond_q;
        assign g_evt[gi] = grp_if[gi].event_q;
        assign g_en[gi] = grp_if[gi].enable_q;
        assign g_ptr[gi] = grp_if[gi].ptr_q;
        assign g_ntr[gi] = grp_if[gi].ntr_q;
        iss_status_group #(
            .MASK(GRP_MASK[gi])
        ) u_grp (
            .i_ref_clk(i_ref_clk),
            .i_srst(i_srst),
            .g(grp_if[gi])
        );
    end

    // General event sources; no condition register, every event is latched
    always_comb begin
        gen_set = 16'h0000;
        gen_set[`ISS_EV_OPC] = s.opc_armed && i_ops_idle;
        gen_set[`ISS_EV_OQF] = i_output_queue_fault;
        gen_set[`ISS_EV_ISF] = i_instrument_specific_fault;
        gen_set[`ISS_EV_CNE] = i_command_not_executable;
        gen_set[`ISS_EV_MFC] = i_malformed_command;
    end

    // Summary byte assembly; bit 6 is the live master summary
    assign gen_summary = |(s.gen_evt & s.gen_en);
    always_comb begin
        sum_bits = 8'h00;
        sum_bits[`ISS_STB_ERRQ] = i_error_queue_nonempty;
        sum_bits[`ISS_STB_QSUM] = sums[2];
        sum_bits[`ISS_STB_MSGP] = i_output_message_pending;
        sum_bits[`ISS_STB_GSUM] = gen_summary;
        sum_bits[`ISS_STB_OPSUM] = sums[3];
    end
    assign master_summary = |(sum_bits & s.sre);
    assign stb_now = sum_bits | ({7'h00, master_summary} << `ISS_STB_RQS);

    // Next state of the core
    always_comb begin
        next_s = s;
        next_s.stb = stb_now & `ISS_STB_USED;
        next_s.rsp_valid = 1'b0;
        next_s.rsp_data = 16'h0000;
        // Event latch; a fresh event beats a read or clear in the same cycle
        if (clr_all || (i_cmd_valid && sel_gen && i_cmd == ISS_CMD_READ_EVT)) begin
            next_s.gen_evt = 16'h0000;
        end
        next_s.gen_evt = (next_s.gen_evt | gen_set) & `ISS_EV_MASK;
        // Completion waits for idle; arming while idle still takes one cycle
        if (s.opc_armed && i_ops_idle) begin
            next_s.opc_armed = 1'b0;
        end
        if (clr_all) begin
            next_s.opc_armed = 1'b0;
        end
        if (i_cmd_valid && i_cmd == ISS_CMD_OPC_ARM) begin
            next_s.opc_armed = 1'b1;
        end
        // Request latch: raised on a new master summary, cleared by serial poll
        if (i_cmd_valid && i_cmd == ISS_CMD_SERIAL_POLL) begin
            next_s.srq = 1'b0;
        end
        if (master_summary && !s.stb[`ISS_STB_RQS]) begin
            next_s.srq = 1'b1;
        end
        // Register accesses; reads answer one cycle later
        if (i_cmd_valid) begin
            case (i_cmd)
                ISS_CMD_WRITE_EN: begin
                    if (sel_gen) begin
                        next_s.gen_en = i_cmd_wdata & `ISS_EV_MASK;
                    end
                end
                ISS_CMD_WRITE_SRE: begin
                    next_s.sre = i_cmd_wdata[7:0] & `ISS_STB_USED
                        & ~(8'h01 << `ISS_STB_RQS);
                end
                ISS_CMD_READ_COND: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = sel_gen ? 16'h0000 : g_cond[i_cmd_grp[1:0]];
                end
                ISS_CMD_READ_EVT: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = sel_gen ? s.gen_evt : g_evt[i_cmd_grp[1:0]];
                end
                ISS_CMD_READ_EN: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = sel_gen ? s.gen_en : g_en[i_cmd_grp[1:0]];
                end
                ISS_CMD_READ_PTR: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = sel_gen ? 16'h0000 : g_ptr[i_cmd_grp[1:0]];
                end
                ISS_CMD_READ_NTR: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = sel_gen ? 16'h0000 : g_ntr[i_cmd_grp[1:0]];
                end
                ISS_CMD_READ_SRE: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = {8'h00, s.sre};
                end
                ISS_CMD_STB_QUERY: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = {8'h00, s.stb};
                end
                ISS_CMD_SERIAL_POLL: begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = {8'h00, (s.stb & ~(8'h01 << `ISS_STB_RQS))
                        | ({7'h00, s.srq} << `ISS_STB_RQS)};
                end
                default: begin
                end
            endcase
        end
    end

    // State register; reset doubles as power-up, so it leaves the power-on event set
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s <= '{gen_evt: 16'h0001 << `ISS_EV_PWR, gen_en: `ISS_EN_RST,
                sre: `ISS_SRE_RST, stb: 8'h00, srq: 1'b0, opc_armed: 1'b0,
                rsp_valid: 1'b0, rsp_data: 16'h0000};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign o_rsp_valid = s.rsp_valid;
    assign o_rsp_data = s.rsp_data;
    assign o_srq = s.srq;
    assign o_summary_byte = s.stb;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    sequence opc_arm_s;
        i_cmd_valid && i_cmd == ISS_CMD_OPC_ARM;
    endsequence
    sequence opc_done_s;
        !i_ops_idle [*1] ##1 i_ops_idle;
    endsequence
    sequence poll_s;
        i_cmd_valid && i_cmd == ISS_CMD_SERIAL_POLL;
    endsequence

    errq_bit_a: assert property (i_error_queue_nonempty |=> o_summary_byte[2])
        else $error("error queue bit not raised");
    qs_bit_a: assert property (sums[2] |=> o_summary_byte[3])
        else $error("questionable bit not raised");
    msg_bit_a: assert property (!i_output_message_pending |=> !o_summary_byte[4])
        else $error("message bit set with empty queue");
    gsum_bit_a: assert property ((gen_summary != 1'b0) |=> o_summary_byte[5])
        else $error("general event summary not in byte");
    op_bit_a: assert property ($rose(sums[3]) |=> o_summary_byte[7])
        else $error("operation bit not raised");
    srq_poll_a: assert property (master_summary && !s.stb[6] ##1 poll_s
        |=> o_rsp_valid && o_rsp_data[6] && !o_srq)
        else $error("serial poll lost the request bit");
    master_live_a: assert property (i_cmd_valid && i_cmd == ISS_CMD_STB_QUERY
        |=> o_rsp_data[6] == $past(s.stb[6])
        ##1 o_summary_byte[6] == $past(master_summary))
        else $error("query bit 6 not the live master summary");
    gen_latch_a: assert property (i_malformed_command |=> s.gen_evt[5])
        else $error("general event not latched");
    opc_wait_a: assert property (opc_arm_s ##1 opc_done_s |=> s.gen_evt[0])
        else $error("completion bit missing after idle");
    opc_busy_a: assert property (opc_arm_s ##1 (!i_ops_idle && !s.gen_evt[0]) [*2]
        |=> !s.gen_evt[0])
        else $error("completion bit set while busy");
    oqf_set_a: assert property (i_output_queue_fault |=> s.gen_evt[2])
        else $error("query error not latched");
    isf_set_a: assert property (i_instrument_specific_fault |=> s.gen_evt[3])
        else $error("device error not latched");
    cne_set_a: assert property (i_command_not_executable |=> s.gen_evt[4])
        else $error("execution error not latched");
    pwr_set_a: assert property ($fell(i_srst) |-> s.gen_evt[7])
        else $error("power-on bit missing after reset");
    clk_route_a: assert property (sums[0] |-> qs_cond[5] && qs_cond[9])
        else $error("clock summary not routed");
    sym_route_a: assert property (sums[1] |-> qs_cond[12])
        else $error("symbol summary not routed");
    unused_zero_a: assert property ((o_summary_byte[1:0] == 2'b00)
        && ((s.gen_evt | s.gen_en) & ~`ISS_EV_MASK) == 16'h0000)
        else $error("unused bit set");
endmodule : iss_status_core

// ==== iss_status_group.sv ====
// One condition / transition / event / enable status group
`timescale 1ns/1ns
`include "iss_regs.svh"
module iss_status_group import iss_pkg::*; #(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    iss_grp_if.grp g
);
    iss_grp_state_t s;
    iss_grp_state_t next_s;
    logic [15:0] cond_m;
    logic [15:0] hits;

    // Condition follows the monitored inputs with no latching
    assign cond_m = g.cond & MASK;
    assign hits = ((cond_m & ~s.cond_prev & s.ptr) | (~cond_m & s.cond_prev & s.ntr));

    // Next state; a new hit wins over a read or clear in the same cycle
    always_comb begin
        next_s = s;
        next_s.cond_prev = cond_m;
        next_s.evt = ((g.rd_evt | g.clr) ? 16'h0000 : s.evt) | hits;
        if (g.wr_ptr) begin
            next_s.ptr = g.wdata & MASK;
        end
        if (g.wr_ntr) begin
            next_s.ntr = g.wdata & MASK;
        end
        if (g.wr_en) begin
            next_s.en = g.wdata & MASK;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s <= '{cond_prev: 16'h0000, ptr: `ISS_PTR_RST & MASK, ntr: `ISS_NTR_RST,
                en: `ISS_EN_RST, evt: 16'h0000};
        end else begin
            s <= next_s;
        end
    end

    assign g.cond_q = cond_m;
    assign g.event_q = s.evt;
    assign g.enable_q = s.en;
    assign g.ptr_q = s.ptr;
    assign g.ntr_q = s.ntr;
    assign g.summary = |(s.evt & s.en);

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    grp_rise_latch_a: assert property ((|hits) |=> ((s.evt & $past(hits)) == $past(hits)))
        else $error("transition not latched into event");
    grp_event_hold_a: assert property (!g.rd_evt && !g.clr |=> ((s.evt & $past(s.evt)) == $past(s.evt)))
        else $error("event bit dropped without read or clear");
    grp_summary_or_a: assert property (g.summary == |(g.event_q & g.enable_q))
        else $error("group summary is not OR of enabled events");
    grp_unused_zero_a: assert property (((s.evt | s.en | s.ptr | s.ntr) & ~MASK) == 16'h0000)
        else $error("unused group bit is set");
endmodule : iss_status_group

// ==== tb_top.sv ====
// Self-checking bench for the status reporting core
`timescale 1ns/1ns
`include "iss_regs.svh"
module tb_top import iss_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ops_idle = 1'b1;
    logic [3:0] flt = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic eq_ne = 1'b0;
    logic msg_pend = 1'b0;
    logic [15:0] qs_in = 16'h0000;
    logic [15:0] op_in = 16'h0000;
    logic cmd_valid;
    iss_cmd_t cmd;
    logic [2:0] grp;
    logic [15:0] wdata;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic srq;
    logic [7:0] sbyte;
    int fail_count = 0;
    int tests_run = 0;

    // Free-running reference clock
    always #5 clk = ~clk;

    iss_status_core i_dut (
        .i_ref_clk(clk), .i_srst(srst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_cmd_grp(grp), .i_cmd_wdata(wdata), .i_ops_idle(ops_idle),
        .i_output_queue_fault(flt[0]), .i_instrument_specific_fault(flt[1]),
        .i_command_not_executable(flt[2]), .i_malformed_command(flt[3]),
        .i_error_queue_nonempty(eq_ne), .i_output_message_pending(msg_pend),
        .i_detector_clock_missing(lvl[0]), .i_generator_clock_missing(lvl[1]),
        .i_symbol_align_lost(lvl[2]), .i_symbol_align_done(lvl[3]),
        .i_questionable_cond(qs_in), .i_operation_cond(op_in), .o_rsp_valid(rsp_valid),
        .o_rsp_data(rsp_data), .o_srq(srq), .o_summary_byte(sbyte)
    );

    iss_ctrl_model i_ctrl (
        .i_ref_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
        .o_cmd(cmd), .o_cmd_valid(cmd_valid), .o_cmd_grp(grp), .o_cmd_wdata(wdata)
    );

    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] act, input logic [15:0] exp);
        tests_run++;
        if (act !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, act, exp);
        end
    endtask : check

    task automatic bit_is(input logic act, input logic exp);
        check({15'h0000, act}, {15'h0000, exp});
    endtask : bit_is

    // Read command: answer must come, masked data compared
    task automatic rd(input iss_cmd_t c, input logic [2:0] g, input logic [15:0] m,
                      input logic [15:0] exp);
        logic got;
        logic [15:0] d;
        i_ctrl.xfer(c, g, 16'h0000, got, d);
        bit_is(got, 1'b1);
        check(d & m, exp);
    endtask : rd

    // Write command: no answer expected
    task automatic wr(input iss_cmd_t c, input logic [2:0] g, input logic [15:0] wd);
        logic got;
        logic [15:0] d;
        i_ctrl.xfer(c, g, wd, got, d);
        bit_is(got, 1'b0);
    endtask : wr

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic t_reset();
        check({6'h00, srq, rsp_valid, sbyte}, 16'h0000);
        rd(ISS_CMD_READ_EVT, 3'h4, 16'hFFFF, 16'h0080);
        rd(ISS_CMD_READ_EVT, 3'h4, 16'hFFFF, 16'h0000);
        rd(ISS_CMD_READ_PTR, 3'h4, 16'hFFFF, 16'h0000);
        rd(ISS_CMD_READ_PTR, 3'h0, 16'hFFFF, 16'h0003);
    endtask : t_reset

    // Each fault input latches its own general event bit and drives bit 5
    task automatic t_gen_events();
        wr(ISS_CMD_WRITE_EN, 3'h4, 16'hFFFF);
        rd(ISS_CMD_READ_EN, 3'h4, 16'hFFFF, `ISS_EV_MASK);
        for (int k = 0; k < 4; k++) begin
            flt[k] = 1'b1;
            wait_cyc(1);
            flt = 4'h0;
            wait_cyc(3);
            bit_is(sbyte[5], 1'b1);
            rd(ISS_CMD_READ_EVT, 3'h4, 16'hFFFF, 16'h0001 << (k + 2));
            wait_cyc(3);
            bit_is(sbyte[5], 1'b0);
        end
    endtask : t_gen_events

    // Completion bit waits for the pending work to finish
    task automatic t_opc();
        ops_idle = 1'b0;
        wr(ISS_CMD_OPC_ARM, 3'h4, 16'h0000);
        wait_cyc(5);
        rd(ISS_CMD_READ_EVT, 3'h4, 16'h0001, 16'h0000);
        ops_idle = 1'b1;
        wait_cyc(3);
        rd(ISS_CMD_READ_EVT, 3'h4, 16'h0001, 16'h0001);
    endtask : t_opc

    task automatic t_levels();
        eq_ne = 1'b1;
        wait_cyc(2);
        bit_is(sbyte[2], 1'b1);
        eq_ne = 1'b0;
        msg_pend = 1'b1;
        wait_cyc(2);
        check({14'h0000, sbyte[4], sbyte[2]}, 16'h0002);
        msg_pend = 1'b0;
        wait_cyc(2);
        bit_is(sbyte[4], 1'b0);
    endtask : t_levels

    // Clock-loss and symbol conditions climb through the questionable group to bit 3
    task automatic t_lower();
        logic [15:0] exp;
        wr(ISS_CMD_WRITE_EN, 3'h0, 16'hFFFF);
        rd(ISS_CMD_READ_EN, 3'h0, 16'hFFFF, 16'h0003);
        wr(ISS_CMD_WRITE_EN, 3'h1, 16'hFFFF);
        wr(ISS_CMD_WRITE_EN, 3'h2, 16'h1220);
        for (int i = 0; i < 4; i++) begin
            wr(ISS_CMD_CLEAR_STATUS, 3'h0, 16'h0000);
            lvl = 4'h1 << i;
            exp = 16'h0001 << (i % 2);
            wait_cyc(8);
            rd(ISS_CMD_READ_COND, 3'(i / 2), 16'hFFFF, exp);
            rd(ISS_CMD_READ_COND, 3'h2, 16'h1220, (i < 2) ? 16'h0220 : 16'h1000);
            bit_is(sbyte[3], 1'b1);
            rd(ISS_CMD_READ_EVT, 3'(i / 2), 16'hFFFF, exp);
            lvl = 4'h0;
            wait_cyc(4);
        end
    endtask : t_lower

    task automatic t_operation();
        wr(ISS_CMD_WRITE_EN, 3'h3, 16'hFFFF);
        op_in = 16'h0008;
        wait_cyc(4);
        bit_is(sbyte[7], 1'b1);
        rd(ISS_CMD_READ_EVT, 3'h3, 16'hFFFF, 16'h0008);
        op_in = 16'h0000;
        wait_cyc(3);
        bit_is(sbyte[7], 1'b0);
    endtask : t_operation

    // Poll returns the latched request and clears it; the query shows the live summary
    task automatic t_srq();
        wr(ISS_CMD_WRITE_SRE, 3'h0, 16'h0004);
        eq_ne = 1'b1;
        wait_cyc(4);
        check({14'h0000, srq, sbyte[6]}, 16'h0003);
        rd(ISS_CMD_STB_QUERY, 3'h0, 16'h0044, 16'h0044);
        rd(ISS_CMD_STB_QUERY, 3'h0, 16'h0040, 16'h0040);
        rd(ISS_CMD_SERIAL_POLL, 3'h0, 16'h0040, 16'h0040);
        bit_is(srq, 1'b0);
        rd(ISS_CMD_SERIAL_POLL, 3'h0, 16'h0040, 16'h0000);
        rd(ISS_CMD_STB_QUERY, 3'h0, 16'h0040, 16'h0040);
        eq_ne = 1'b0;
        wait_cyc(3);
        rd(ISS_CMD_STB_QUERY, 3'h0, 16'h0044, 16'h0000);
    endtask : t_srq

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_gen_events();
        t_opc();
        t_levels();
        t_lower();
        t_operation();
        t_srq();
        report_and_stop();
    end

    // Watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        #100000;
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb_top
